/* verilog/clock_source_select.sv */
// clock source selection, prescaler, trim and start-up delay
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module clock_source_select #(
  parameter int SHORT_CYCLES = clock_source_select_pkg::START_SHORT_CYCLES,
  parameter int LONG_CYCLES = clock_source_select_pkg::START_LONG_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] clock_source_code,
  input wire logic wake_request,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [2:0] selected_source,
  output logic [3:0] clock_divide_setting,
  output logic [7:0] rc_trim_value,
  output logic rc_range_select_bit,
  output logic clock_ready
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [3:0] code_meta_reg;
  logic [3:0] code_sync_reg;
  logic wake_meta_reg;
  logic wake_sync_reg;
  logic wake_prev_reg;

  always_ff @(posedge aclk)
  begin
    code_meta_reg <= clock_source_code;
    code_sync_reg <= code_meta_reg;
    wake_meta_reg <= wake_request;
    wake_sync_reg <= wake_meta_reg;
    wake_prev_reg <= wake_sync_reg;
  end

  // ------------------------------------------------------------
  // source decode
  // ------------------------------------------------------------
  function automatic clock_source_select_pkg::clock_source_e decode_source(
    input logic [3:0] code
  );
    clock_source_select_pkg::clock_source_e src;
    src = clock_source_select_pkg::src_none;
    if (code == clock_source_select_pkg::CODE_EXT_CLOCK)
      src = clock_source_select_pkg::src_ext_clock;
    else if (code == clock_source_select_pkg::CODE_PLL)
      src = clock_source_select_pkg::src_pll;
    else if (code == clock_source_select_pkg::CODE_INT_RC)
      src = clock_source_select_pkg::src_int_rc;
    else if (code[3:2] == 2'h1)
      src = clock_source_select_pkg::src_low_freq;
    else if (code[3:1] == 3'h4)
      src = clock_source_select_pkg::src_res_low;
    else if (code[3:1] == 3'h5)
      src = clock_source_select_pkg::src_xtal_mid;
    else if (code[3:2] == 2'h3)
      src = clock_source_select_pkg::src_xtal_high;
    // no external RC choice; 0011 stays unused
    return src;
  endfunction : decode_source

  // ------------------------------------------------------------
  // source latch and start-up delay
  // ------------------------------------------------------------
  typedef enum logic [1:0] {st_reset, st_wait, st_run} start_state_e;

  start_state_e state_reg;
  start_state_e state_next;
  clock_source_select_pkg::clock_source_e source_reg;
  clock_source_select_pkg::clock_source_e source_next;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic ready_reg;
  logic ready_next;
  logic [31:0] delay_cycles;

  assign delay_cycles = (source_reg == clock_source_select_pkg::src_pll) ?
    32'(LONG_CYCLES) : 32'(SHORT_CYCLES);

  always_comb
  begin
    state_next = state_reg;
    source_next = source_reg;
    count_next = count_reg;
    ready_next = ready_reg;
    case (state_reg)
      st_reset:
      begin
        state_next = st_wait;
        count_next = 32'h0000_0000;
        ready_next = 1'b0;
      end
      st_wait:
      begin
        if (count_reg + 32'h0000_0001 >= delay_cycles)
        begin
          state_next = st_run;
          ready_next = 1'b1;
        end
        else
          count_next = count_reg + 32'h0000_0001;
      end
      default:
      begin
        if (wake_sync_reg && !wake_prev_reg)
        begin
          state_next = st_wait;
          count_next = 32'h0000_0000;
          ready_next = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= st_reset;
      // sampled while reset held, frozen after
      source_reg <= decode_source(code_sync_reg);
      count_reg <= 32'h0000_0000;
      ready_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      source_reg <= source_next;
      count_reg <= count_next;
      ready_reg <= ready_next;
    end
  end

  // ------------------------------------------------------------
  // register file over axi4-lite
  // ------------------------------------------------------------
  logic [3:0] divide_reg;
  logic [3:0] divide_next;
  logic [7:0] trim_reg;
  logic [7:0] trim_next;
  logic awready_reg;
  logic awready_next;
  logic wready_reg;
  logic wready_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic have_aw_reg;
  logic have_aw_next;
  logic have_w_reg;
  logic have_w_next;
  logic [31:0] waddr_reg;
  logic [31:0] waddr_next;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_next;
  logic [3:0] wstrb_reg;
  logic [3:0] wstrb_next;
  logic arready_reg;
  logic arready_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;

  always_comb
  begin
    divide_next = divide_reg;
    trim_next = trim_reg;
    have_aw_next = have_aw_reg;
    have_w_next = have_w_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    awready_next = !have_aw_reg && !bvalid_reg;
    wready_next = !have_w_reg && !bvalid_reg;
    if (s_axi_awvalid && awready_reg)
    begin
      have_aw_next = 1'b1;
      waddr_next = s_axi_awaddr;
      awready_next = 1'b0;
    end
    if (s_axi_wvalid && wready_reg)
    begin
      have_w_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
      wready_next = 1'b0;
    end
    if (have_aw_reg && have_w_reg && !bvalid_reg)
    begin
      have_aw_next = 1'b0;
      have_w_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = clock_source_select_pkg::RESP_OKAY;
      if (waddr_reg[7:2] == clock_source_select_pkg::CONTROL_OFFSET[7:2] &&
          waddr_reg[31:8] == 24'h00_0000)
      begin
        if (wstrb_reg[0])
          divide_next = wdata_reg[3:0];
      end
      else if (waddr_reg[7:2] == clock_source_select_pkg::TRIM_OFFSET[7:2] &&
               waddr_reg[31:8] == 24'h00_0000)
      begin
        if (wstrb_reg[0])
          trim_next = wdata_reg[7:0];
      end
      else if (waddr_reg[7:2] == clock_source_select_pkg::STATUS_OFFSET[7:2] &&
               waddr_reg[31:8] == 24'h00_0000)
        bresp_next = clock_source_select_pkg::RESP_OKAY;
      else
        bresp_next = clock_source_select_pkg::RESP_DECERR;
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
  end

  always_comb
  begin
    arready_next = !rvalid_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arready_reg)
    begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = clock_source_select_pkg::RESP_OKAY;
      if (s_axi_araddr == clock_source_select_pkg::CONTROL_OFFSET)
        rdata_next = {28'h000_0000, divide_reg};
      else if (s_axi_araddr == clock_source_select_pkg::TRIM_OFFSET)
        rdata_next = {24'h00_0000, trim_reg};
      else if (s_axi_araddr == clock_source_select_pkg::STATUS_OFFSET)
        rdata_next = {27'h000_0000, ready_reg, 1'b0, source_reg};
      else
      begin
        rdata_next = 32'h0000_0000;
        rresp_next = clock_source_select_pkg::RESP_DECERR;
      end
    end
    if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      divide_reg <= clock_source_select_pkg::DIVIDE_RESET;
      trim_reg <= clock_source_select_pkg::TRIM_RESET;
      have_aw_reg <= 1'b0;
      have_w_reg <= 1'b0;
      waddr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end
    else
    begin
      divide_reg <= divide_next;
      trim_reg <= trim_next;
      have_aw_reg <= have_aw_next;
      have_w_reg <= have_w_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign selected_source = source_reg;
  assign clock_divide_setting = divide_reg;
  assign rc_trim_value = trim_reg;
  assign rc_range_select_bit =
    trim_reg[clock_source_select_pkg::TRIM_RANGE_POS];
  assign clock_ready = ready_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  source_held_a: assert property ($stable(source_reg))
    else $error("clock source changed outside reset");
  no_ready_wait_a: assert property (state_reg == st_wait |-> !ready_reg)
    else $error("clock released during start-up wait");
  pll_long_a: assert property (
    (state_reg == st_wait && source_reg == clock_source_select_pkg::src_pll)
      |-> count_reg < 32'(LONG_CYCLES))
    else $error("pll start-up count overran");
  range_bit_a: assert property (
    (have_aw_reg && have_w_reg && !bvalid_reg &&
     waddr_reg == clock_source_select_pkg::TRIM_OFFSET && wstrb_reg[0])
      |=> rc_range_select_bit ==
        $past(wdata_reg[clock_source_select_pkg::TRIM_RANGE_POS]))
    else $error("range bit not from trim top bit");
  rc_code_a: assert property (disable iff (1'b0)
    (!aresetn && code_sync_reg == clock_source_select_pkg::CODE_INT_RC)
      |=> source_reg == clock_source_select_pkg::src_int_rc)
    else $error("rc source decode");
  no_ext_rc_a: assert property (disable iff (1'b0)
    (!aresetn && code_sync_reg == 4'h3)
      |=> source_reg == clock_source_select_pkg::src_none)
    else $error("external rc chosen");
  divide_write_a: assert property (
    (have_aw_reg && have_w_reg && !bvalid_reg && waddr_reg == 32'h0 &&
     wstrb_reg[0]) |=> clock_divide_setting == $past(wdata_reg[3:0]))
    else $error("divide setting not written");
  bresp_follow_a: assert property (
    (have_aw_reg && have_w_reg && !bvalid_reg) |=> bvalid_reg)
    else $error("write response missing");
  ready_cover_c: cover property (ready_reg);
  wake_cover_c: cover property (ready_reg ##1 state_reg == st_wait);
  read_cover_c: cover property (rvalid_reg && s_axi_rready);

endmodule : clock_source_select

/* verilog/clock_source_select_pkg.sv */
// constants and types for the clock source selection block
package clock_source_select_pkg;

  typedef enum logic [2:0] {
    src_ext_clock,
    src_pll,
    src_int_rc,
    src_low_freq,
    src_res_low,
    src_xtal_mid,
    src_xtal_high,
    src_none
  } clock_source_e;

  typedef struct packed {
    logic [31:0] addr;
  } axi_addr_s;

  localparam logic [31:0] CONTROL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] TRIM_OFFSET = 32'h0000_0004;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0008;

  localparam logic [3:0] CODE_EXT_CLOCK = 4'h0;
  localparam logic [3:0] CODE_PLL = 4'h1;
  localparam logic [3:0] CODE_INT_RC = 4'h2;
  localparam logic [3:0] DIVIDE_RESET = 4'h0;
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam int TRIM_RANGE_POS = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  localparam int CLOCK_PERIOD_NS = 10;
  localparam int START_SHORT_US = 4;
  localparam int START_LONG_US = 64;
  localparam int START_SHORT_CYCLES = START_SHORT_US * 1000 / CLOCK_PERIOD_NS;
  localparam int START_LONG_CYCLES = START_LONG_US * 1000 / CLOCK_PERIOD_NS;

endpackage : clock_source_select_pkg

/* testbench/tb_clock_source_select.sv */
// self-checking testbench for the clock source selection block
`timescale 1ns/1ps
module tb_clock_source_select;
  localparam int SC = 4;
  localparam int LC = 16;
  localparam logic [1:0] OK = clock_source_select_pkg::RESP_OKAY;
  localparam logic [1:0] DE = clock_source_select_pkg::RESP_DECERR;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [3:0] code = 4'h2;
  logic [3:0] strb = 4'hF;
  logic wake = 1'h0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, rdy, rng;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] src;
  logic [3:0] div;
  logic [7:0] trim;
  logic [2:0] exp_tab [16] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h3, 3'h3, 3'h3,
    3'h3, 3'h4, 3'h4, 3'h5, 3'h5, 3'h6, 3'h6, 3'h6, 3'h6};
  int failures = 0;
  int checked = 0;
  int n;

  always #5 aclk = ~aclk;

  clock_source_select #(.SHORT_CYCLES(SC), .LONG_CYCLES(LC)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .clock_source_code(code),
    .wake_request(wake), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .selected_source(src), .clock_divide_setting(div),
    .rc_trim_value(trim), .rc_range_select_bit(rng), .clock_ready(rdy)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic wait_rdy;
    n = 0;
    while (rdy !== 1'h1 && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_rdy

  task automatic rst(input logic [3:0] c);
    code <= c;
    aresetn <= 1'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    wait_rdy();
  endtask : rst

  task automatic wr(input logic [31:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk(bresp, er, "write response");
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] ev,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rresp, er, "read response");
    if (er == OK) chk(rdata, ev, "read data");
    @(posedge aclk);
  endtask : rd

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    @(posedge aclk);
    for (int c = 0; c < 16; c++)
    begin
      rst(c[3:0]);
      chk(src, exp_tab[c], "decoded source");
      chk(div, 4'h0, "prescaler reset");
      chk({rng, trim}, {1'h1, 8'h80}, "trim reset");
      if (c == 1)
        chk(n >= LC && n < LC + 8, 1, "long start-up");
      else
        chk(n >= SC && n < LC, 1, "short start-up");
    end
    $display("test done: source codes");
    rst(4'h2);
    wr(32'h0, 32'h5, OK);
    chk(div, 4'h5, "prescaler output");
    rd(32'h0, 32'h5, OK);
    strb <= 4'hE;
    wr(32'h0, 32'hA, OK);
    chk(div, 4'h5, "masked byte ignored");
    strb <= 4'hF;
    wr(32'h4, 32'h05, OK);
    chk({rng, trim}, {1'h0, 8'h05}, "low range trim");
    wr(32'h4, 32'h85, OK);
    chk({rng, trim}, {1'h1, 8'h85}, "high range trim");
    rd(32'h4, 32'h85, OK);
    rd(32'h8, 32'h12, OK);
    wr(32'h8, 32'hFF, OK);
    rd(32'h8, 32'h12, OK);
    wr(32'h40, 32'h1, DE);
    rd(32'h40, 32'h0, DE);
    $display("test done: registers");
    code <= 4'h1;
    repeat (8) @(posedge aclk);
    chk(src, 3'h2, "source held after reset");
    rd(32'h8, 32'h12, OK);
    $display("test done: source held");
    for (int k = 0; k < 2; k++)
    begin
      rst(k == 0 ? 4'h2 : 4'h1);
      wake <= 1'h1;
      repeat (4) @(posedge aclk);
      chk(rdy, 1'h0, "ready dropped on wake");
      wait_rdy();
      chk(n >= (k == 0 ? SC : LC) - 1 && n < (k == 0 ? SC : LC) + 4, 1,
          "wake start-up");
      wake <= 1'h0;
      @(posedge aclk);
    end
    $display("test done: wake");
    summarize();
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    failures++;
    summarize();
  end
endmodule : tb_clock_source_select
